// ===== dv/fdt_dma_ctrl_assertions.sv
// checker: port-level properties of the dma threshold control
`timescale 1ns/1ps
module fdt_dma_ctrl_assertions
import fdt_pkg::*;
#(
    parameter int FIFO_BYTES = 32
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire fdt_pkg::fdt_cfg_t cfg_in,
    input wire logic [fdt_pkg::CNT_W-1:0] rx_fifo_bytes_in,
    input wire logic [fdt_pkg::CNT_W-1:0] tx_fifo_bytes_in,
    input wire logic tx_pending_in,
    input wire logic bus_grant_in,
    input wire logic mem_ack_in,
    input wire logic bus_req_out,
    input wire logic rx_beat_out,
    input wire logic tx_beat_out,
    input wire logic rx_burst_out,
    input wire logic tx_burst_out,
    input wire logic burst_done_out,
    input wire logic [fdt_pkg::CNT_W-1:0] burst_units_out
);
    // ------------------------------------------------------------
    // threshold helpers
    // ------------------------------------------------------------
    function automatic int thu(input logic [1:0] c, input logic w);
        return ((c == 2'h3) ? 24 : 4 << c) >> (w ? 2 : 1);
    endfunction
    int ub, rxu, txu;
    logic rxc, txc;
    assign ub = cfg_in.wide_bus ? 4 : 2;
    assign rxu = thu(cfg_in.rx_fifo_level_code, cfg_in.wide_bus);
    assign txu = thu(cfg_in.tx_fifo_level_code, cfg_in.wide_bus);
    assign rxc = rx_fifo_bytes_in >= rxu * ub;
    assign txc = tx_pending_in && (tx_fifo_bytes_in < txu * ub);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_idle;
        !bus_req_out && !burst_done_out && !$past(burst_done_out);
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_rx_req_raise: assert property (s_idle ##0 rxc |=> bus_req_out)
        else $error("rx request not raised");
    a_tx_req_raise: assert property (s_idle ##0 txc |=> bus_req_out)
        else $error("tx request not raised");
    a_no_early_req: assert property (s_idle ##0 (!rxc && !txc) |=> !bus_req_out)
        else $error("request without cause");
    a_rx_not_empty: assert property (rx_beat_out |-> rx_fifo_bytes_in >= ub)
        else $error("rx beat on empty fifo");
    a_tx_not_full: assert property (tx_beat_out |-> FIFO_BYTES - tx_fifo_bytes_in >= ub)
        else $error("tx beat on full fifo");
    a_rx_block_cap: assert property (rx_beat_out && cfg_in.burst_style_select
        |-> burst_units_out < rxu) else $error("rx block overrun");
    a_tx_block_cap: assert property (tx_beat_out && cfg_in.burst_style_select
        |-> burst_units_out < txu) else $error("tx block overrun");
    a_fill_runs: assert property (rx_burst_out && !cfg_in.burst_style_select
        && !burst_done_out && rx_fifo_bytes_in >= ub |-> rx_beat_out)
        else $error("rx burst stalled");
    a_tx_fill_runs: assert property (tx_burst_out && !cfg_in.burst_style_select
        && FIFO_BYTES - tx_fifo_bytes_in >= ub |-> tx_beat_out)
        else $error("tx burst stalled");
    a_done_pulse: assert property (burst_done_out |-> !bus_req_out ##1 !burst_done_out)
        else $error("done not a pulse");
    c_rx_block: cover property (rx_burst_out && cfg_in.burst_style_select && burst_done_out);
    c_tx_fill: cover property (tx_beat_out && !cfg_in.burst_style_select && mem_ack_in);
    c_wide_done: cover property (burst_done_out && cfg_in.wide_bus);
endmodule

bind fdt_dma_ctrl fdt_dma_ctrl_assertions #(.FIFO_BYTES(FIFO_BYTES)) u_chk (.*);

// ===== dv/fdt_dma_ctrl_tb_top.sv
// testbench: random bursts against an integer reference of the dma control
`timescale 1ns/1ps
module fdt_dma_ctrl_tb_top;
    import fdt_pkg::*;
    logic core_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    fdt_cfg_t cfg = '0;
    logic [5:0] rx_lvl = 6'h00;
    logic [5:0] tx_lvl = 6'h00;
    logic pend = 1'b0;
    logic slow = 1'b0;
    logic grant, ack, req, rxb, txb, rxbu, txbu, done;
    logic [5:0] units;
    int seed = 32'ha5e06ccc;
    int failures = 0;
    int total_checks = 0;
    int rx_moved, tx_moved, ub, rxu, txu, rxf, txf, dir, exp_u, n;
    int seen_rx, seen_tx;
    int exp_q[$];
    fdt_dma_ctrl fdt_dma_ctrl_i (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .cfg_in(cfg), .rx_fifo_bytes_in(rx_lvl), .tx_fifo_bytes_in(tx_lvl),
        .tx_pending_in(pend), .bus_grant_in(grant), .mem_ack_in(ack), .bus_req_out(req),
        .rx_beat_out(rxb), .tx_beat_out(txb), .rx_burst_out(rxbu), .tx_burst_out(txbu),
        .burst_done_out(done), .burst_units_out(units));
    fdt_mem_model fdt_mem_model_i (.core_clk_in(core_clk_in), .slow_in(slow),
        .bus_req_in(req), .beat_in(rxb | txb), .bus_grant_out(grant), .mem_ack_out(ack));
    // ------------------------------------------------------------
    // clock, fifo levels and helpers
    // ------------------------------------------------------------
    initial begin
        forever #25 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin
        if (rxb && ack) begin
            rx_lvl <= rx_lvl - 6'(ub);
            rx_moved++;
        end
        if (txb && ack) begin
            tx_lvl <= tx_lvl + 6'(ub);
            tx_moved++;
        end
    end
    function automatic int thb(input logic [1:0] c);
        return (c == 2'h3) ? 24 : 4 << c;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(negedge core_clk_in);
        reset_n_in = 1'b1;
        check("bus_req_out reset", req, 0);
        check("burst_done_out reset", done, 0);
        check("burst_units_out reset", units, 0);
        for (int i = 0; i < 112; i++) begin
            @(negedge core_clk_in);
            cfg = 6'($random(seed));
            slow = ($random(seed) & 1) != 0;
            if (i < 32) begin
                cfg.rx_fifo_level_code = i[1:0];
                cfg.burst_style_select = i[2];
                cfg.wide_bus = i[3];
            end
            ub = cfg.wide_bus ? 4 : 2;
            rxu = thb(cfg.rx_fifo_level_code) / ub;
            txu = thb(cfg.tx_fifo_level_code) / ub;
            rxf = (i < 32) ? rxu - i[4] : ($random(seed) & 32'hff) % (FIFO_BYTES / ub + 1);
            txf = ($random(seed) & 32'hff) % (FIFO_BYTES / ub + 1);
            pend = (i >= 32) && (($random(seed) & 1) != 0);
            rx_lvl = 6'(rxf * ub);
            tx_lvl = 6'(txf * ub);
            rx_moved = 0;
            tx_moved = 0;
            dir = 0;
            if (rxf >= rxu) begin
                dir = 1;
                exp_u = cfg.burst_style_select ? rxu : rxf;
            end else if (pend && txf < txu) begin
                dir = 2;
                exp_u = FIFO_BYTES / ub - txf;
                if (cfg.burst_style_select && txu < exp_u) exp_u = txu;
            end
            if (dir == 0) begin
                repeat (4) begin
                    @(negedge core_clk_in);
                    check("bus_req_out idle", req, 0);
                end
            end else begin
                exp_q.push_back(exp_u);
                n = 0;
                seen_rx = 0;
                seen_tx = 0;
                while (done !== 1'b1 && n < 200) begin
                    @(negedge core_clk_in);
                    if (rxbu === 1'b1) seen_rx = 1;
                    if (txbu === 1'b1) seen_tx = 1;
                    n++;
                end
                check("burst_done_out", done, 1);
                check("burst_units_out", units, exp_q.pop_front());
                check("rx_burst_out seen", seen_rx, dir == 1);
                check("tx_burst_out seen", seen_tx, dir == 2);
                check("rx units moved", rx_moved, (dir == 1) ? exp_u : 0);
                check("tx units moved", tx_moved, (dir == 2) ? exp_u : 0);
                rx_lvl = 6'h00;
                pend = 1'b0;
                repeat (2) @(negedge core_clk_in);
                check("bus_req_out after", req, 0);
            end
        end
        finish_test();
    end
    initial begin
        #1000000;
        failures++;
        finish_test();
    end
endmodule

// ===== dv/fdt_mem_model.sv
// model: system bus arbiter and memory answering dma beats
`timescale 1ns/1ps
module fdt_mem_model (
    input wire logic core_clk_in,
    input wire logic slow_in,
    input wire logic bus_req_in,
    input wire logic beat_in,
    output logic bus_grant_out = 1'b0,
    output logic mem_ack_out = 1'b0
);
    int seed = 32'ha5e06ccc;
    int wait_n = 0;
    // grant after a random delay and ack beats with random stalls, both only when slow
    always @(negedge core_clk_in) begin
        if (!bus_req_in) begin
            bus_grant_out <= 1'b0;
            wait_n = slow_in ? ($random(seed) & 3) : 0;
        end else if (wait_n > 0) begin
            wait_n--;
        end else begin
            bus_grant_out <= 1'b1;
        end
        mem_ack_out <= beat_in && bus_grant_out && (!slow_in || ($random(seed) & 1) != 0);
    end
endmodule

// ===== verilog/fdt_dma_ctrl.sv
// module: dma burst control driven by fifo thresholds and burst style
`timescale 1ns/1ps
module fdt_dma_ctrl #(
    parameter int FIFO_BYTES = fdt_pkg::FIFO_BYTES
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire fdt_pkg::fdt_cfg_t cfg_in,
    input wire logic [fdt_pkg::CNT_W-1:0] rx_fifo_bytes_in,
    input wire logic [fdt_pkg::CNT_W-1:0] tx_fifo_bytes_in,
    input wire logic tx_pending_in,
    input wire logic bus_grant_in,
    input wire logic mem_ack_in,
    output logic bus_req_out,
    output logic rx_beat_out,
    output logic tx_beat_out,
    output logic rx_burst_out,
    output logic tx_burst_out,
    output logic burst_done_out,
    output logic [fdt_pkg::CNT_W-1:0] burst_units_out
);
    import fdt_pkg::*;

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (FIFO_BYTES < int'(FIFO_MIN_BYTES) || FIFO_BYTES > 63) begin : g_bad_depth
        $error("fifo depth must lie between 24 and 63 bytes");
    end
    if (CNT_W < 6) begin : g_bad_width
        $error("count width too narrow for the fifo depth");
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic fdt_ends(input fdt_state_t s, input logic rx_e, input logic tx_e);
        return (s == FDT_RX && rx_e) || (s == FDT_TX && tx_e);
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    fdt_state_t state_q;
    fdt_state_t state_d;
    logic [CNT_W-1:0] rx_thr;
    logic [CNT_W-1:0] rx_fill;
    logic [CNT_W-1:0] tx_thr;
    logic [CNT_W-1:0] tx_fill;
    logic [CNT_W-1:0] tx_room;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] limit_q;
    logic block_q;
    logic dir_tx_q;
    logic done_q;
    logic rx_wants;
    logic tx_wants;
    logic limit_hit;
    logic rx_end;
    logic tx_end;
    logic beat_done;
    logic start_now;
    logic burst_end;

    // ----------------------------------------------------------------
    // threshold gauges
    // ----------------------------------------------------------------
    fdt_level_gauge #(
        .FIFO_BYTES(FIFO_BYTES)
    ) u_rx_gauge (
        .level_code_bits_in(cfg_in.rx_fifo_level_code),
        .fill_bytes_in(rx_fifo_bytes_in),
        .wide_bus_in(cfg_in.wide_bus),
        .thresh_units_out(rx_thr),
        .fill_units_out(rx_fill),
        .room_units_out()
    );

    fdt_level_gauge #(
        .FIFO_BYTES(FIFO_BYTES)
    ) u_tx_gauge (
        .level_code_bits_in(cfg_in.tx_fifo_level_code),
        .fill_bytes_in(tx_fifo_bytes_in),
        .wide_bus_in(cfg_in.wide_bus),
        .thresh_units_out(tx_thr),
        .fill_units_out(tx_fill),
        .room_units_out(tx_room)
    );

    // ----------------------------------------------------------------
    // request conditions
    // ----------------------------------------------------------------
    // receive is served ahead of transmit
    assign rx_wants = (rx_fill >= rx_thr);
    assign tx_wants = tx_pending_in && (tx_fill < tx_thr);
    assign start_now = (state_q == FDT_IDLE) && (rx_wants || tx_wants);

    // ----------------------------------------------------------------
    // burst end conditions
    // ----------------------------------------------------------------
    assign limit_hit = block_q && (count_q >= limit_q);
    assign rx_end = (rx_fill == CNT_RESET) || limit_hit;
    assign tx_end = (tx_room == CNT_RESET) || limit_hit;
    assign burst_end = fdt_ends(state_q, rx_end, tx_end);

    // ----------------------------------------------------------------
    // handshake outputs
    // ----------------------------------------------------------------
    assign bus_req_out = (state_q == FDT_REQ) || (state_q == FDT_RX) || (state_q == FDT_TX);
    assign rx_beat_out = (state_q == FDT_RX) && !rx_end;
    assign tx_beat_out = (state_q == FDT_TX) && !tx_end;
    assign rx_burst_out = (state_q == FDT_RX);
    assign tx_burst_out = (state_q == FDT_TX);
    assign beat_done = (rx_beat_out || tx_beat_out) && mem_ack_in;

    // ----------------------------------------------------------------
    // data outputs
    // ----------------------------------------------------------------
    assign burst_done_out = done_q;
    assign burst_units_out = count_q;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            FDT_IDLE: begin
                if (start_now) begin
                    state_d = FDT_REQ;
                end
            end
            FDT_REQ: begin
                if (bus_grant_in) begin
                    state_d = dir_tx_q ? FDT_TX : FDT_RX;
                end
            end
            FDT_RX: begin
                if (rx_end) begin
                    state_d = FDT_END;
                end
            end
            FDT_TX: begin
                if (tx_end) begin
                    state_d = FDT_END;
                end
            end
            FDT_END: begin
                state_d = FDT_IDLE;
            end
            default: begin
                state_d = FDT_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= FDT_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // direction captured at request, receive first
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dir_tx_q <= 1'b0;
        end else if (start_now) begin
            dir_tx_q <= !rx_wants;
        end
    end

    // ----------------------------------------------------------------
    // burst style captured at request
    // ----------------------------------------------------------------
    // held for the whole burst so a burst_style_select change mid-burst waits for the next one
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            block_q <= BURST_EMPTY_FILL;
        end else if (start_now) begin
            block_q <= cfg_in.burst_style_select;
        end
    end

    // ----------------------------------------------------------------
    // block limit captured at request
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            limit_q <= CNT_RESET;
        end else if (start_now) begin
            limit_q <= rx_wants ? rx_thr : tx_thr;
        end
    end

    // ----------------------------------------------------------------
    // units moved in the current burst
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_q <= CNT_RESET;
        end else if (state_q == FDT_REQ) begin
            count_q <= CNT_RESET;
        end else if (beat_done) begin
            count_q <= count_q + CNT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // burst done pulse
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            done_q <= 1'b0;
        end else begin
            done_q <= burst_end;
        end
    end

endmodule

// ===== verilog/fdt_level_gauge.sv
// module: converts a level code and fifo byte fill into bus-width units
`timescale 1ns/1ps
module fdt_level_gauge #(
    parameter int FIFO_BYTES = fdt_pkg::FIFO_BYTES
) (
    input wire logic [1:0] level_code_bits_in,
    input wire logic [fdt_pkg::CNT_W-1:0] fill_bytes_in,
    input wire logic wide_bus_in,
    output logic [fdt_pkg::CNT_W-1:0] thresh_units_out,
    output logic [fdt_pkg::CNT_W-1:0] fill_units_out,
    output logic [fdt_pkg::CNT_W-1:0] room_units_out
);
    import fdt_pkg::*;

    if (FIFO_BYTES < 1 || FIFO_BYTES > 63) begin : g_bad_depth
        $error("fifo depth does not fit the byte count width");
    end

    localparam logic [CNT_W-1:0] DEPTH_BYTES = CNT_W'(FIFO_BYTES);

    logic [CNT_W-1:0] room_bytes;

    // ----------------------------------------------------------------
    // unit conversion
    // ----------------------------------------------------------------
    assign room_bytes = (fill_bytes_in >= DEPTH_BYTES) ? CNT_RESET : DEPTH_BYTES - fill_bytes_in;
    assign thresh_units_out = fdt_to_units(fdt_level_bytes(level_code_bits_in), wide_bus_in);
    assign fill_units_out = fdt_to_units(fill_bytes_in, wide_bus_in);
    assign room_units_out = fdt_to_units(room_bytes, wide_bus_in);

endmodule

// ===== verilog/fdt_pkg.sv
// package: constants, types and helpers for the fifo dma threshold control
package fdt_pkg;

    // ----------------------------------------------------------------
    // sizes and reset values
    // ----------------------------------------------------------------
    localparam int FIFO_BYTES = 32;
    localparam int CNT_W = 6;
    localparam logic [5:0] CNT_RESET = 6'h00;
    localparam logic [5:0] FIFO_MIN_BYTES = 6'h18;

    // ----------------------------------------------------------------
    // burst style encodings
    // ----------------------------------------------------------------
    localparam logic BURST_EMPTY_FILL = 1'b0;
    localparam logic BURST_BLOCK = 1'b1;

    // ----------------------------------------------------------------
    // level code to byte counts
    // ----------------------------------------------------------------
    localparam logic [1:0] LEVEL_CODE_00 = 2'h0;
    localparam logic [1:0] LEVEL_CODE_01 = 2'h1;
    localparam logic [1:0] LEVEL_CODE_10 = 2'h2;
    localparam logic [5:0] LEVEL_BYTES_00 = 6'h04;
    localparam logic [5:0] LEVEL_BYTES_01 = 6'h08;
    localparam logic [5:0] LEVEL_BYTES_10 = 6'h10;
    localparam logic [5:0] LEVEL_BYTES_11 = 6'h18;

    // ----------------------------------------------------------------
    // unit size shifts
    // ----------------------------------------------------------------
    localparam int WORD_SHIFT = 1;
    localparam int LONG_SHIFT = 2;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic burst_style_select;
        logic wide_bus;
        logic [1:0] rx_fifo_level_code;
        logic [1:0] tx_fifo_level_code;
    } fdt_cfg_t;

    typedef enum logic [2:0] {
        FDT_IDLE,
        FDT_REQ,
        FDT_RX,
        FDT_TX,
        FDT_END
    } fdt_state_t;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [5:0] fdt_level_bytes(input logic [1:0] level_code_bits);
        logic [5:0] b;
        case (level_code_bits)
            LEVEL_CODE_00: b = LEVEL_BYTES_00;
            LEVEL_CODE_01: b = LEVEL_BYTES_01;
            LEVEL_CODE_10: b = LEVEL_BYTES_10;
            default: b = LEVEL_BYTES_11;
        endcase
        return b;
    endfunction

    function automatic logic [5:0] fdt_to_units(input logic [5:0] bytes, input logic wide);
        return wide ? (bytes >> LONG_SHIFT) : (bytes >> WORD_SHIFT);
    endfunction

endpackage
